// >>> logic/touch_event_qualifier.v
// touch event qualifier: repeat gating, signal guard, touch limit, pattern detect
// assumes one result strobe per sensing cycle with deltas, thresholds and
// noise flags stable during that strobe; repeat interval given in cycles
//
// How it works
// (R01) repeat off: interrupt on touch and release only
// (R02) repeat on: interrupt at touch, then periodically
// (R03) three repeat enables, reset all set
// (R04) any guard enabled disables input two
// (R05) guard bits at 0 and 2, reset off
// (R06) limit enable bit 7 resets set
// (R07) report up to limit, latch accepted inputs
// (R08) after release reselect first N in order
// (R09) limit code 00=1, 01=2, 1x=3
// (R10) blocked extra touches set limit flag
// (R11) pattern enable bit 7, reset off
// (R12) pattern threshold 12.5, 25, 37.5, 100 percent
// (R13) standby inputs use the standby threshold
// (R14) compare mode: every masked input must qualify
// (R15) count mode: qualifying count reaches mask count
// (R16) evaluate one sensing cycle at a time
// (R17) pattern event blocks touches, sets flag
// (R18) blocking lasts while pattern condition holds
// (R19) pattern flag cleared by global write after
// (R20) notify enable gates pin, flag always set
// (R21) three-bit mask, reset all set
// (R22) per-input interrupt enable gates notify pin
// (R23) repeat interval is an external input
// (R24) pattern blocking overrides touch limiting
`timescale 1ns/100ps
`include "touch_qual_map.vh"
`default_nettype none

module touch_event_qualifier (
	// clock, reset, enable
	input wire clock,
	input wire sys_rst,
	input wire clk_en,
	// measurement results, one strobe per sensing cycle
	input wire cycle_done,
	input wire [23:0] delta_counts,
	input wire [20:0] touch_thresholds,
	input wire [6:0] standby_threshold,
	input wire [2:0] standby_select,
	input wire [2:0] noise_flags,
	input wire [7:0] repeat_interval,
	// qualified results
	output wire [2:0] touch_report,
	output wire [2:0] input_active,
	output reg notify_ff,
	// axi4-lite slave
	input wire [9:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [9:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [7:0] repeat_enable_ff;
reg [7:0] guard_enable_ff;
reg [7:0] touch_limit_ff;
reg [7:0] pattern_config_ff;
reg [7:0] pattern_mask_ff;
reg [7:0] int_enable_ff;
reg [7:0] qual_control_ff;
reg touch_limit_flag_ff;
reg pattern_event_flag_ff;
reg [2:0] touch_report_ff;
reg pattern_active_ff;
reg [7:0] repeat_cnt_ff [0:2];

reg [9:0] aw_addr_ff;
reg aw_held_ff;
reg [31:0] w_data_ff;
reg [3:0] w_strb_ff;
reg w_held_ff;

// ----------------------------------------------------------------
// decode helpers
// ----------------------------------------------------------------
// limit code to touch count; upper codes both saturate at three
function [1:0] limit_count;
	input [1:0] code;
	begin
		case (code)
			2'b00: limit_count = 2'd1;
			2'b01: limit_count = 2'd2;
			default: limit_count = 2'd3;
		endcase
	end
endfunction

// scale a 7-bit threshold by the pattern fraction, kept in eighths
function [9:0] scale_th;
	input [6:0] th;
	input [1:0] sel;
	begin
		case (sel)
			2'b00: scale_th = {3'b000, th};
			2'b01: scale_th = {2'b00, th, 1'b0};
			2'b10: scale_th = {3'b000, th} + {2'b00, th, 1'b0};
			default: scale_th = {th, 3'b000};
		endcase
	end
endfunction

function [1:0] popcount3;
	input [2:0] v;
	begin
		popcount3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
	end
endfunction

wire limit_enable = touch_limit_ff[`LIMIT_ENABLE_BIT];
wire [1:0] limit_n = limit_count(touch_limit_ff[`LIMIT_COUNT_LSB+1:`LIMIT_COUNT_LSB]); // see (R09)
wire pattern_enable = pattern_config_ff[`PATTERN_ENABLE_BIT]; // see (R11)
wire [1:0] pattern_sel = pattern_config_ff[`PATTERN_TH_LSB+1:`PATTERN_TH_LSB];
wire pattern_mode = pattern_config_ff[`PATTERN_MODE_BIT];
wire pattern_notify = pattern_config_ff[`PATTERN_NOTIFY_BIT];
wire release_report = qual_control_ff[`CTRL_RELEASE_BIT];
wire guard_any = guard_enable_ff[`GUARD_ONE_BIT] | guard_enable_ff[`GUARD_THREE_BIT];

assign input_active = {1'b1, ~guard_any, 1'b1}; // see (R04)

// ----------------------------------------------------------------
// per-input comparison
// ----------------------------------------------------------------
wire [2:0] raw_touch;
wire [2:0] pattern_hit;
genvar gi;
generate
	for (gi = 0; gi < 3; gi = gi + 1) begin : g_cmp
		wire [7:0] delta = delta_counts[gi*8 +: 8];
		// standby inputs compare against the shared standby level
		wire [6:0] th = standby_select[gi] ? standby_threshold
			: touch_thresholds[gi*7 +: 7]; // see (R13)
		assign raw_touch[gi] = input_active[gi] & ~delta[7] & (delta[6:0] > th);
		// compare in eighths to keep the fractions exact
		assign pattern_hit[gi] = input_active[gi] & ((~delta[7] &
			({delta[6:0], 3'b000} > scale_th(th, pattern_sel))) | noise_flags[gi]); // see (R12)
	end
endgenerate

// ----------------------------------------------------------------
// pattern condition and touch limiting
// ----------------------------------------------------------------
wire [2:0] mask = pattern_mask_ff[2:0]; // see (R21)
wire pattern_match = pattern_mode ? ((pattern_hit & mask) == mask) // see (R14)
	: (popcount3(pattern_hit) >= popcount3(mask)); // see (R15)
wire pattern_cond = pattern_enable & pattern_match;

reg [2:0] nxt_report;
reg [1:0] taken;
integer k;
always @* begin
	nxt_report = 3'b000;
	taken = 2'd0;
	if (!limit_enable) begin
		nxt_report = raw_touch; // see (R06)
	end else if ((touch_report_ff & raw_touch) == touch_report_ff && touch_report_ff != 3'b000) begin
		// accepted inputs stay latched until one lets go
		nxt_report = touch_report_ff; // see (R07)
	end else begin
		for (k = 0; k < 3; k = k + 1) begin
			if (raw_touch[k] && taken < limit_n) begin
				nxt_report[k] = 1'b1; // see (R08)
				taken = taken + 2'd1;
			end
		end
	end
	if (pattern_cond) begin
		nxt_report = 3'b000; // see (R17) (R24)
	end
end

wire limit_over = limit_enable & ~pattern_cond & (popcount3(raw_touch) > limit_n); // see (R10)
assign touch_report = touch_report_ff;

// ----------------------------------------------------------------
// bus write path
// ----------------------------------------------------------------
wire do_write = aw_held_ff & w_held_ff & ~s_axi_bvalid;
wire [7:0] w_idx = aw_addr_ff[9:2];
wire w_byte0 = w_strb_ff[0];
wire global_clear = do_write && w_idx == `QUAL_CONTROL_IDX && w_byte0
	&& !w_data_ff[`CTRL_GLOBAL_INT_BIT];

assign s_axi_awready = ~aw_held_ff;
assign s_axi_wready = ~w_held_ff;
assign s_axi_arready = ~s_axi_rvalid;

function mapped;
	input [7:0] idx;
	begin
		case (idx)
			`REPEAT_ENABLE_IDX, `GUARD_ENABLE_IDX, `TOUCH_LIMIT_IDX,
			`PATTERN_CONFIG_IDX, `PATTERN_MASK_IDX, `TOUCH_STATUS_IDX,
			`QUAL_CONTROL_IDX, `INT_ENABLE_IDX: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
endfunction

always @(posedge clock) begin
	if (sys_rst) begin
		aw_held_ff <= 1'b0;
		w_held_ff <= 1'b0;
		aw_addr_ff <= 10'h000;
		w_data_ff <= 32'h00000000;
		w_strb_ff <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'b00;
		repeat_enable_ff <= `REPEAT_ENABLE_RST; // see (R03)
		guard_enable_ff <= `GUARD_ENABLE_RST; // see (R05)
		touch_limit_ff <= `TOUCH_LIMIT_RST;
		pattern_config_ff <= `PATTERN_CONFIG_RST;
		pattern_mask_ff <= `PATTERN_MASK_RST;
		int_enable_ff <= `INT_ENABLE_RST;
		qual_control_ff <= `QUAL_CONTROL_RST;
	end else if (clk_en) begin
		if (s_axi_awvalid && !aw_held_ff) begin
			aw_addr_ff <= s_axi_awaddr;
			aw_held_ff <= 1'b1;
		end
		if (s_axi_wvalid && !w_held_ff) begin
			w_data_ff <= s_axi_wdata;
			w_strb_ff <= s_axi_wstrb;
			w_held_ff <= 1'b1;
		end
		if (do_write) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(w_idx) ? 2'b00 : 2'b10;
			if (w_byte0) begin
				case (w_idx)
					`REPEAT_ENABLE_IDX: repeat_enable_ff <= {5'h00, w_data_ff[2:0]};
					`GUARD_ENABLE_IDX: guard_enable_ff <= {5'h00, w_data_ff[2], 1'b0, w_data_ff[0]};
					`TOUCH_LIMIT_IDX: touch_limit_ff <= {w_data_ff[7], 3'b000, w_data_ff[3:2], 2'b00};
					`PATTERN_CONFIG_IDX: pattern_config_ff <= {w_data_ff[7], 3'b000, w_data_ff[3:0]};
					`PATTERN_MASK_IDX: pattern_mask_ff <= {5'h00, w_data_ff[2:0]};
					`QUAL_CONTROL_IDX: qual_control_ff <= {6'h00, w_data_ff[1:0]};
					`INT_ENABLE_IDX: int_enable_ff <= {5'h00, w_data_ff[2:0]};
					default: ;
				endcase
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------
// bus read path
// ----------------------------------------------------------------
reg [7:0] rd_byte;
wire [7:0] r_idx = s_axi_araddr[9:2];
always @* begin
	case (r_idx)
		`REPEAT_ENABLE_IDX: rd_byte = repeat_enable_ff;
		`GUARD_ENABLE_IDX: rd_byte = guard_enable_ff;
		`TOUCH_LIMIT_IDX: rd_byte = touch_limit_ff;
		`PATTERN_CONFIG_IDX: rd_byte = pattern_config_ff;
		`PATTERN_MASK_IDX: rd_byte = pattern_mask_ff;
		`TOUCH_STATUS_IDX: rd_byte = {3'b000, pattern_event_flag_ff, touch_limit_flag_ff,
			touch_report_ff};
		`QUAL_CONTROL_IDX: rd_byte = {6'h00, notify_ff, release_report};
		`INT_ENABLE_IDX: rd_byte = int_enable_ff;
		default: rd_byte = 8'h00;
	endcase
end

always @(posedge clock) begin
	if (sys_rst) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= 2'b00;
	end else if (clk_en) begin
		if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_byte};
			s_axi_rresp <= mapped(r_idx) ? 2'b00 : 2'b10;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------
// qualification state and notify
// ----------------------------------------------------------------
reg [2:0] touch_irq;
reg [2:0] rpt_hit;
integer j;
integer q;
always @* begin
	touch_irq = 3'b000;
	rpt_hit = 3'b000;
	for (j = 0; j < 3; j = j + 1) begin
		// fire repeats only when the interval has elapsed
		rpt_hit[j] = repeat_enable_ff[j] && touch_report_ff[j] && nxt_report[j]
			&& repeat_interval != 8'h00 && repeat_cnt_ff[j] + 8'h01 >= repeat_interval; // see (R02)
		touch_irq[j] = int_enable_ff[j] && ((nxt_report[j] && !touch_report_ff[j]) // see (R22)
			|| (release_report && !nxt_report[j] && touch_report_ff[j]) // see (R01)
			|| rpt_hit[j]);
	end
end

wire pattern_rise = pattern_cond & ~pattern_active_ff;

always @(posedge clock) begin
	if (sys_rst) begin
		touch_report_ff <= 3'b000;
		pattern_active_ff <= 1'b0;
		touch_limit_flag_ff <= 1'b0;
		pattern_event_flag_ff <= 1'b0;
		notify_ff <= 1'b0;
		repeat_cnt_ff[0] <= 8'h00;
		repeat_cnt_ff[1] <= 8'h00;
		repeat_cnt_ff[2] <= 8'h00;
	end else if (clk_en) begin
		if (cycle_done) begin // see (R16)
			touch_report_ff <= nxt_report;
			pattern_active_ff <= pattern_cond; // see (R18)
			for (q = 0; q < 3; q = q + 1) begin
				repeat_cnt_ff[q] <= (rpt_hit[q] || !nxt_report[q]) ? 8'h00
					: repeat_cnt_ff[q] + 8'h01; // see (R23)
			end
		end
		// set beats clear on the same cycle
		if (cycle_done && limit_over) begin
			touch_limit_flag_ff <= 1'b1;
		end else if (global_clear) begin
			touch_limit_flag_ff <= 1'b0;
		end
		// flag survives until cleared after the condition has gone
		if (cycle_done && pattern_rise) begin
			pattern_event_flag_ff <= 1'b1; // see (R17)
		end else if (global_clear && !pattern_active_ff && !pattern_cond) begin
			pattern_event_flag_ff <= 1'b0; // see (R19)
		end
		if (cycle_done && ((|touch_irq) || (pattern_rise && pattern_notify))) begin
			notify_ff <= 1'b1; // see (R20)
		end else if (global_clear) begin
			notify_ff <= 1'b0;
		end
	end
end

endmodule
`default_nettype wire

// >>> logic/touch_qual_map.vh
// register offsets, field positions and reset values for the touch qualifier
// assumes byte addressing on a 32-bit AXI4-Lite bus, one word per register
`ifndef TOUCH_QUAL_MAP_VH
`define TOUCH_QUAL_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define REPEAT_ENABLE_IDX 8'h28
`define GUARD_ENABLE_IDX 8'h29
`define TOUCH_LIMIT_IDX 8'h2A
`define PATTERN_CONFIG_IDX 8'h2B
`define PATTERN_MASK_IDX 8'h2D
`define TOUCH_STATUS_IDX 8'h40
`define QUAL_CONTROL_IDX 8'h41
`define INT_ENABLE_IDX 8'h42

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define REPEAT_ENABLE_RST 8'h07
`define GUARD_ENABLE_RST 8'h00
`define TOUCH_LIMIT_RST 8'h80
`define PATTERN_CONFIG_RST 8'h00
`define PATTERN_MASK_RST 8'h07
`define INT_ENABLE_RST 8'h07
`define QUAL_CONTROL_RST 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define GUARD_ONE_BIT 0
`define GUARD_THREE_BIT 2
`define LIMIT_ENABLE_BIT 7
`define LIMIT_COUNT_LSB 2
`define PATTERN_ENABLE_BIT 7
`define PATTERN_TH_LSB 2
`define PATTERN_MODE_BIT 1
`define PATTERN_NOTIFY_BIT 0
`define CTRL_RELEASE_BIT 0
`define CTRL_GLOBAL_INT_BIT 1
`define STAT_LIMIT_BIT 3
`define STAT_PATTERN_BIT 4

`endif

// >>> verification/touch_event_qualifier_properties.sv
// port-level checks for the touch event qualifier
// assumes the design's ports only, one clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module touch_event_qualifier_properties (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	// results
	input wire logic cycle_done,
	input wire logic [23:0] delta_counts,
	input wire logic [20:0] touch_thresholds,
	input wire logic [6:0] standby_threshold,
	input wire logic [2:0] standby_select,
	input wire logic [2:0] touch_report,
	input wire logic [2:0] input_active,
	input wire logic notify_ff,
	// bus
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [2:0] raw;
	// negative deltas never count as a touch
	always_comb
		for (int i = 0; i < 3; i++)
			raw[i] = $signed(delta_counts[8*i+:8]) > $signed({1'b0,
				standby_select[i] ? standby_threshold : touch_thresholds[7*i+:7]});
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_report_needs_touch: assert property (cycle_done && clk_en
		|=> (touch_report & ~$past(raw)) == 3'h0)
		else $error("report without raw touch");
	a_guard_blocks_two: assert property (cycle_done && !input_active[1] |=> !touch_report[1])
		else $error("guarded input two reported");
	a_outer_inputs_on: assert property (input_active[0] && input_active[2])
		else $error("outer input disabled");
	a_notify_on_cycle: assert property ($rose(notify_ff) |-> $past(cycle_done))
		else $error("notify rose outside sensing cycle");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_write_after_both: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
		else $error("response before address and data");
	a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
		else $error("bad write response code");
	cover property (cycle_done ##1 touch_report != 3'h0);
	cover property ($rose(notify_ff));
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind touch_event_qualifier touch_event_qualifier_properties chk_u (.clock, .sys_rst, .clk_en, .cycle_done,
	.delta_counts, .touch_thresholds, .standby_threshold, .standby_select, .touch_report,
	.input_active, .notify_ff, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// >>> verification/axi_lite_host.sv
// host side: axi4-lite master, one write and one read at a time
// assumes readies and answers change only at rising edges
`timescale 1ns/100ps
`default_nettype none
module axi_lite_host (
	input wire logic clock,
	output logic [9:0] awaddr, output logic awvalid, input wire logic awready,
	output logic [31:0] wdata, output logic wvalid, input wire logic wready,
	input wire logic bvalid, input wire logic [1:0] bresp, output logic bready,
	output logic [9:0] araddr, output logic arvalid, input wire logic arready,
	input wire logic rvalid, input wire logic [31:0] rdata, input wire logic [1:0] rresp,
	output logic rready
);
	initial {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
	// levels seen at the falling edge equal those at the next rising edge
	task automatic wr(input logic [9:0] a, input logic [7:0] d, output logic [1:0] r);
		logic at, wt, bt;
		at = 0;
		wt = 0;
		@(posedge clock);
		awaddr <= a; wdata <= {24'h000000, d}; awvalid <= 1; wvalid <= 1;
		do begin
			@(negedge clock); at = at | awready; wt = wt | wready;
			@(posedge clock); if (at) awvalid <= 0; if (wt) wvalid <= 0;
		end while (!(at && wt));
		// ready held back so the slave must keep its response standing
		repeat (2) @(posedge clock);
		bready <= 1;
		do begin
			@(negedge clock); bt = bvalid; r = bresp;
			@(posedge clock);
		end while (!bt);
		bready <= 0;
	endtask
	task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
		logic t;
		@(posedge clock);
		araddr <= a; arvalid <= 1;
		do begin @(negedge clock); t = arready; @(posedge clock); end while (!t);
		arvalid <= 0;
		@(posedge clock);
		rready <= 1;
		do begin @(negedge clock); t = rvalid; d = rdata; r = rresp; @(posedge clock); end while (!t);
		rready <= 0;
	endtask
endmodule
`default_nettype wire

// >>> verification/touch_event_qualifier_bench.sv
// self-checking bench for the touch event qualifier
// assumes the host model for register traffic; thresholds 16, touch deltas 0x30
`timescale 1ns/100ps
`default_nettype none
module touch_event_qualifier_bench;
	logic clock = 0, sys_rst = 1, cycle_done = 0, clk_en = 1;
	logic [23:0] delta_counts = 0;
	logic [20:0] touch_thresholds = {3{7'h10}};
	logic [6:0] standby_threshold = 7'h10;
	logic [2:0] standby_select = 0, noise_flags = 0;
	logic [7:0] repeat_interval = 8'h03;
	wire [9:0] awaddr, araddr;
	wire [31:0] wdata, rdata;
	wire [1:0] bresp, rresp;
	wire [2:0] touch_report, input_active;
	wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, notify_ff;
	int miscompares = 0, tests_run = 0, cycles = 0;
	logic [31:0] d;
	logic [1:0] r;
	axi_lite_host host_u (.clock(clock), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bresp(bresp),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
		.rdata(rdata), .rresp(rresp), .rready(rready));
	touch_event_qualifier dut_u (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
		.cycle_done(cycle_done), .delta_counts(delta_counts), .touch_thresholds(touch_thresholds),
		.standby_threshold(standby_threshold), .standby_select(standby_select),
		.noise_flags(noise_flags), .repeat_interval(repeat_interval), .touch_report(touch_report),
		.input_active(input_active), .notify_ff(notify_ff), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	initial forever #12.5 clock = ~clock;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task complete_run;
		if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin miscompares = miscompares + 1; complete_run; end
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task rdchk(input logic [9:0] a, input logic [31:0] e); host_u.rd(a, d, r); check(d, e); endtask
	task wr(input logic [9:0] a, input logic [7:0] v); host_u.wr(a, v, r); check(r, 2'h0); endtask
	task rst; @(posedge clock); sys_rst <= 1; repeat (2) @(posedge clock); sys_rst <= 0; endtask
	task sense(input logic [23:0] dl, input logic [2:0] n);
		@(posedge clock); delta_counts <= dl; noise_flags <= n; cycle_done <= 1;
		@(posedge clock); cycle_done <= 0; @(negedge clock);
	endtask
	task clear_pattern; sense(0, 0); rdchk(10'h100, 32'h10); sense(0, 0); wr(10'h104, 0); endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task reset_values;
		rdchk(10'h0A0, 32'h07); rdchk(10'h0A4, 32'h00); rdchk(10'h0A8, 32'h80);
		rdchk(10'h0AC, 32'h00); rdchk(10'h0B4, 32'h07);
		rdchk(10'h108, 32'h07); rdchk(10'h100, 32'h00);
		host_u.rd(10'h3FC, d, r); check(r, 2'h2);
	endtask
	task limit_test;
		rst;
		sense(24'h303000, 0); check(touch_report, 3'h2); rdchk(10'h100, 32'h0A);
		sense(24'h303030, 0); check(touch_report, 3'h2);
		sense(24'h300030, 0); check(touch_report, 3'h1);
		for (int i = 0; i < 4; i++) begin
			wr(10'h0A8, 8'h80 | (i << 2)); wr(10'h104, 0); sense(0, 0); sense(24'h303030, 0);
			check(touch_report, i == 0 ? 3'h1 : i == 1 ? 3'h3 : 3'h7);
		end
		rdchk(10'h100, 32'h07);
		wr(10'h0A8, 0); sense(0, 0); sense(24'h303030, 0); check(touch_report, 3'h7);
	endtask
	task guard_test;
		rst; wr(10'h0A8, 0); wr(10'h0A4, 1); check(input_active, 3'h5);
		sense(24'h303030, 0); check(touch_report, 3'h5);
		// a frozen block ignores the sensing strobe
		@(posedge clock); clk_en <= 0; sense(0, 0); check(touch_report, 3'h5);
		@(posedge clock); clk_en <= 1;
		wr(10'h0A4, 4); check(input_active, 3'h5); wr(10'h0A4, 0); check(input_active, 3'h7);
		standby_select <= 3'h1; standby_threshold <= 7'h40; sense(24'h300030, 0);
		check(touch_report, 3'h4);
		@(posedge clock); standby_select <= 3'h0;
	endtask
	task pattern_test;
		logic [7:0] m;
		rst; wr(10'h0A8, 0);
		for (int j = 0; j < 4; j++) begin
			m = j == 0 ? 8'h02 : j == 1 ? 8'h04 : j == 2 ? 8'h06 : 8'h10;
			wr(10'h0AC, 8'h80 | (j << 2)); sense({3{m}}, 0); rdchk(10'h100, 32'h00);
			sense({3{m + 8'h01}}, 0); rdchk(10'h100, 32'h10);
			check(notify_ff, 0);
			clear_pattern; rdchk(10'h100, 32'h00);
		end
		wr(10'h0AC, 8'h82); wr(10'h0B4, 5); sense(24'h000005, 0); rdchk(10'h100, 32'h00);
		sense(24'h000005, 3'h4); rdchk(10'h100, 32'h10); clear_pattern;
		wr(10'h0AC, 8'h81); wr(10'h0B4, 7); wr(10'h0A8, 8'h80); sense(24'h303030, 0);
		rdchk(10'h100, 32'h10); check(notify_ff, 1); check(touch_report, 0);
	endtask
	task repeat_test;
		rst; wr(10'h0A0, 0); sense(24'h000030, 0); check(notify_ff, 1); wr(10'h104, 0);
		repeat (4) sense(24'h000030, 0);
		check(notify_ff, 0);
		wr(10'h0A0, 1); wr(10'h104, 0); repeat (4) sense(24'h000030, 0);
		check(notify_ff, 1);
		wr(10'h108, 0); sense(0, 0); wr(10'h104, 0); sense(24'h000030, 0);
		check(notify_ff, 0);
		wr(10'h108, 7); wr(10'h104, 1); check(notify_ff, 0);
		sense(0, 0); check(notify_ff, 1);
	endtask
	initial begin
		repeat (4) @(posedge clock);
		sys_rst <= 0;
		reset_values;
		limit_test;
		guard_test;
		pattern_test;
		repeat_test;
		complete_run;
	end
endmodule
`default_nettype wire
